//--- verilog/prn_port.sv
// Parallel printer port: data latch, status input and control latch
// Function
// R01: Data read returns current data line levels
// R02: Data read is latch ORed with external drive
// R03: Printer must not drive data lines; the bench printer model drives them from de
// R04: Status bits 7..3 are live input lines
// R05: Control read: lines in 3..0, enable in 4
// R06: Undriven control read equals last written value
// R07: Control line read is latch OR external
// R08: Reset: enable, bit2 clear; bits 3,1,0 set
// R09: Interrupt request gated by control enable bit
// R10: Interrupt request output is active high
// R11: Writes load data byte and control bits 4..0
`timescale 1ns/1ps
module prn_port (
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [9:0] io_addr_i,
  input  wire logic       io_rd_i,
  input  wire logic       io_wr_i,
  input  wire logic [7:0] io_wdata_i,
  output logic      [7:0] io_rdata_o,
  output logic            io_rvalid_o,
  output logic      [7:0] data_pins_o,
  input  wire logic [7:0] data_pins_i,
  input  wire logic [4:0] status_pins_i,
  output logic      [3:0] ctrl_pins_o,
  input  wire logic [3:0] ctrl_pins_i,
  output logic            irq_o
);

  prn_pins_if pins ();

  logic [7:0] data_q;
  logic [3:0] ctrl_q;
  logic       irq_en_q;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic       irq_q;

  // Raw pin levels go through the synchronisers before use
  assign pins.data_raw   = data_pins_i;
  assign pins.status_raw = status_pins_i;
  assign pins.ctrl_raw   = ctrl_pins_i;

  prn_pin_sync u_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .pins       (pins)
  );

  // Address decode
  wire sel_data   = prn_port_pkg::addr_hit(io_addr_i,
                                           prn_port_pkg::DATA_ADDR);
  wire sel_status = prn_port_pkg::addr_hit(io_addr_i,
                                           prn_port_pkg::STATUS_ADDR);
  wire sel_ctrl   = prn_port_pkg::addr_hit(io_addr_i,
                                           prn_port_pkg::CTRL_ADDR);
  wire wr_data    = io_wr_i & sel_data;
  wire wr_ctrl    = io_wr_i & sel_ctrl;

  // Line levels as the pins would show them, wired-OR style
  wire [7:0] data_level = data_q | pins.data_sync;          // [R01] [R02]
  wire [3:0] ctrl_level = ctrl_q | pins.ctrl_sync;          // [R07] [R06]

  // Read values per register; undefined status bits read zero
  wire [7:0] status_rd = {pins.status_sync, 3'h0};          // [R04]
  wire [7:0] ctrl_rd   = {3'h0, irq_en_q, ctrl_level};      // [R05]

  // Read data select; unmapped addresses answer like an idle bus
  wire [7:0] rd_mux = sel_data   ? data_level :
                      sel_status ? status_rd  :
                      sel_ctrl   ? ctrl_rd    :
                      prn_port_pkg::UNMAPPED_RD;

  // Interrupt source is the acknowledge status line
  wire ack_level = pins.status_sync[prn_port_pkg::ACK_STAT_BIT];
  wire irq_d     = irq_en_q & ack_level;                    // [R09]

  // Data latch
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_q <= prn_port_pkg::DATA_RST;
    end else if (wr_data) begin
      data_q <= io_wdata_i;                                 // [R11]
    end
  end

  // Control latch and interrupt enable
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q   <= prn_port_pkg::CTRL_RST;                   // [R08]
      irq_en_q <= prn_port_pkg::IRQ_EN_RST;                 // [R08]
    end else if (wr_ctrl) begin
      ctrl_q   <= io_wdata_i[3:0];                          // [R11]
      irq_en_q <= io_wdata_i[prn_port_pkg::IRQ_EN_BIT];     // [R11]
    end
  end

  // Read answer registered one cycle after the strobe
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= io_rd_i;
      if (io_rd_i) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Interrupt output, high while enabled and acknowledge is high
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;                                       // [R10]
    end
  end

  // Outputs straight from flip-flops
  assign io_rdata_o  = rdata_q;
  assign io_rvalid_o = rvalid_q;
  assign data_pins_o = data_q;
  assign ctrl_pins_o = ctrl_q;
  assign irq_o       = irq_q;

  // Checks on the register behaviour
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  data_read_a: assert property (                            // [R01] [R02]
    io_rd_i && sel_data |=> io_rvalid_o &&
      io_rdata_o == ($past(data_q) | $past(pins.data_sync)))
    else $error("data port read value wrong");

  status_read_a: assert property (                          // [R04]
    io_rd_i && sel_status |=> io_rdata_o[7:3] ==
      $past(pins.status_sync) && io_rdata_o[2:0] == 3'h0)
    else $error("status port read value wrong");

  ctrl_read_a: assert property (                            // [R05] [R07]
    io_rd_i && sel_ctrl |=> io_rdata_o ==
      {3'h0, $past(irq_en_q), $past(ctrl_q) | $past(pins.ctrl_sync)})
    else $error("control port read value wrong");

  ctrl_echo_a: assert property (                            // [R06]
    wr_ctrl ##1 (io_rd_i && sel_ctrl && pins.ctrl_sync == 4'h0)
      |=> io_rdata_o[4:0] == $past(io_wdata_i[4:0], 2))
    else $error("control read does not echo write");

  reset_value_a: assert property (                          // [R08]
    $past(sys_rst_i) |-> ctrl_pins_o == prn_port_pkg::CTRL_RST &&
      !irq_en_q)
    else $error("control reset value wrong");

  irq_gate_a: assert property (                             // [R09]
    !irq_en_q ##1 !irq_en_q |-> !irq_o)
    else $error("interrupt raised while disabled");

  irq_high_a: assert property (                             // [R10]
    irq_en_q && ack_level |=> irq_o)
    else $error("interrupt not raised high");

  data_write_a: assert property (                           // [R11]
    wr_data |=> data_pins_o == $past(io_wdata_i))
    else $error("data latch not loaded");

  ctrl_write_a: assert property (                           // [R11]
    wr_ctrl |=> ctrl_pins_o == $past(io_wdata_i[3:0]) &&
      irq_en_q == $past(io_wdata_i[prn_port_pkg::IRQ_EN_BIT]))
    else $error("control latch not loaded");

  unmapped_read_a: assert property (
    io_rd_i && !sel_data && !sel_status && !sel_ctrl
      |=> io_rdata_o == prn_port_pkg::UNMAPPED_RD)
    else $error("unmapped read answer wrong");

  // Read valid must drop, answers and latches must hold between strobes
  rvalid_pulse_a: assert property (                         // [R01]
    !io_rd_i |=> !io_rvalid_o)
    else $error("read answer flagged without a read");

  rdata_hold_a: assert property (                           // [R01]
    !io_rd_i |=> $stable(io_rdata_o))
    else $error("read data changed without a read");

  data_hold_a: assert property (                            // [R11]
    !wr_data |=> $stable(data_pins_o))
    else $error("data latch changed without a write");

  ctrl_hold_a: assert property (                            // [R11]
    !wr_ctrl |=> $stable(ctrl_pins_o) && $stable(irq_en_q))
    else $error("control latch changed without a write");

  status_write_a: assert property (                         // [R11]
    io_wr_i && sel_status |=> $stable(data_pins_o) &&
      $stable(ctrl_pins_o) && $stable(irq_en_q))
    else $error("status write changed a latch");

  // Interrupt must stay low while acknowledge is low
  irq_low_a: assert property (                              // [R09]
    !ack_level |=> !irq_o)
    else $error("interrupt raised without acknowledge");

  // Reset also clears the data latch and the request line
  data_reset_a: assert property (                           // [R08]
    $past(sys_rst_i) |-> data_pins_o == prn_port_pkg::DATA_RST &&
      !irq_o)
    else $error("data latch or interrupt reset value wrong");

  // Same-cycle write excluded, the read shows the old latch
  ctrl_undriven_a: assert property (                        // [R06]
    io_rd_i && sel_ctrl && !wr_ctrl && pins.ctrl_sync == 4'h0
      |=> io_rdata_o[3:0] == ctrl_pins_o)
    else $error("undriven control read differs from latch");

  // Main scenarios worth seeing at least once
  data_rd_c: cover property (wr_data ##[1:4] (io_rd_i && sel_data));
  irq_off_c: cover property (irq_o ##1 !irq_o);
  irq_on_c: cover property (wr_ctrl ##[1:8] irq_o);
  status_rd_c: cover property (io_rd_i && sel_status);
  ext_drive_c: cover property (io_rd_i && sel_ctrl &&
                               pins.ctrl_sync != 4'h0);

endmodule

//--- verilog/prn_port_pkg.sv
// Package with the printer port address map, field layout and resets
package prn_port_pkg;

  // I/O byte addresses of the three port registers
  localparam logic [9:0] DATA_ADDR   = 10'h3BC;
  localparam logic [9:0] STATUS_ADDR = 10'h3BD;
  localparam logic [9:0] CTRL_ADDR   = 10'h3BE;

  // Widths of the pin groups
  localparam int DATA_W   = 8;
  localparam int STATUS_W = 5;
  localparam int CTRL_W   = 4;

  // Field positions in the status and control read values
  localparam int STATUS_LSB    = 3;
  localparam int IRQ_EN_BIT    = 4;
  localparam int ACK_STAT_BIT  = 3;  // Index into the five status lines

  // Reset values
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam logic [3:0] CTRL_RST    = 4'hB;
  localparam logic       IRQ_EN_RST  = 1'b0;

  // Answer to a read of an unmapped address, like an idle bus
  localparam logic [7:0] UNMAPPED_RD = 8'hFF;

  // Address compare, used by both read and write decode
  function automatic logic addr_hit(input logic [9:0] addr,
                                    input logic [9:0] reg_addr);
    addr_hit = (addr == reg_addr);
  endfunction

endpackage

//--- verilog/prn_pins_if.sv
// Interface carrying raw and synchronised printer pin levels
`timescale 1ns/1ps
interface prn_pins_if;
  logic [7:0] data_raw;
  logic [4:0] status_raw;
  logic [3:0] ctrl_raw;
  logic [7:0] data_sync;
  logic [4:0] status_sync;
  logic [3:0] ctrl_sync;

  modport sync (input  data_raw,
                input  status_raw,
                input  ctrl_raw,
                output data_sync,
                output status_sync,
                output ctrl_sync);

  modport core (output data_raw,
                output status_raw,
                output ctrl_raw,
                input  data_sync,
                input  status_sync,
                input  ctrl_sync);
endinterface

//--- verilog/prn_pin_sync.sv
// Two-stage synchronisers for every printer pin input
`timescale 1ns/1ps
module prn_pin_sync (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  prn_pins_if.sync  pins
);

  logic [16:0] meta_q;
  logic [16:0] sync_q;

  // First stage is read only by the second stage
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= 17'h00000;
      sync_q <= 17'h00000;
    end else begin
      meta_q <= {pins.ctrl_raw, pins.status_raw, pins.data_raw};
      sync_q <= meta_q;
    end
  end

  // Split the settled levels back into groups
  assign pins.data_sync   = sync_q[7:0];
  assign pins.status_sync = sync_q[12:8];
  assign pins.ctrl_sync   = sync_q[16:13];

endmodule

//--- tb/prn_printer_model.sv
// Printer model: status lines and extra drive on shared lines
`timescale 1ns/1ps
module prn_printer_model (
  input  wire logic       clk_i,
  input  wire logic [4:0] stat_set_i,
  input  wire logic [7:0] dext_set_i,
  input  wire logic [3:0] cext_set_i,
  output logic      [4:0] status_pins_o,
  output logic      [7:0] data_pins_o,
  output logic      [3:0] ctrl_pins_o
);
  // Lines follow the commanded levels one edge later
  always_ff @(posedge clk_i) begin
    status_pins_o <= stat_set_i;
    data_pins_o   <= dext_set_i;
    ctrl_pins_o   <= cext_set_i;
  end
endmodule

//--- tb/printer_parallel_port_tb_top.sv
// Self-checking bench for the printer port against an integer model
`timescale 1ns/1ps
module printer_parallel_port_tb_top;
  logic       clk, rst, rd_s, wr_s, rv, irq;
  logic [9:0] addr;
  logic [7:0] wd, rdat, dpo, dpi, de;
  logic [4:0] spi, st;
  logic [3:0] cpo, cpi, ce;
  int         errors, n_checks, dq, cq, en;
  logic [31:0] seed, r;
  logic [7:0] ex;

  prn_port prn_port_inst (.core_clk_i(clk), .sys_rst_i(rst),
    .io_addr_i(addr), .io_rd_i(rd_s), .io_wr_i(wr_s),
    .io_wdata_i(wd), .io_rdata_o(rdat), .io_rvalid_o(rv),
    .data_pins_o(dpo), .data_pins_i(dpi), .status_pins_i(spi),
    .ctrl_pins_o(cpo), .ctrl_pins_i(cpi), .irq_o(irq));

  prn_printer_model prn_printer_model_inst (.clk_i(clk),
    .stat_set_i(st), .dext_set_i(de), .cext_set_i(ce),
    .status_pins_o(spi), .data_pins_o(dpi), .ctrl_pins_o(cpi));

  // Xorshift keeps the run repeatable
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // Answer lands one cycle after the strobe edge
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk({7'h00, rv}, 8'h01);
    chk(rdat, e);
  endtask

  // Write, then read at the very next edge with no idle cycle
  task automatic wr_rd(input logic [9:0] a, input logic [7:0] d,
                       input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk({7'h00, rv}, 8'h01);
    chk(rdat, e);
  endtask

  task automatic end_sim;
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #40000;
    errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    {rst, rd_s, wr_s, addr, wd} = {1'b1, 20'h0};
    {st, de, ce, errors, n_checks, seed} = {17'h0, 64'h0, 32'd44358};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({4'h0, cpo}, 8'h0B);
    chk({7'h00, irq}, 8'h00);
    rd(prn_port_pkg::CTRL_ADDR, 8'h0B);
    {dq, cq, en} = {32'h0, 32'hB, 32'h0};
    for (int i = 0; i < 30; i++) begin
      seed = xs(seed);
      r = seed;
      wr(prn_port_pkg::DATA_ADDR, r[7:0]);
      wr(prn_port_pkg::CTRL_ADDR, r[15:8]);
      wr(prn_port_pkg::STATUS_ADDR, ~r[7:0]);
      dq = r[7:0];
      cq = r[11:8];
      en = r[12];
      @(posedge clk);
      st <= r[20:16];
      de <= r[21] ? r[31:24] : 8'h00;
      ce <= r[22] ? r[27:24] : 4'h0;
      repeat (5) @(posedge clk);
      #1;
      chk(dpo, 8'(dq));
      chk({4'h0, cpo}, 8'(cq));
      chk({7'h00, irq}, 8'(en & st[3]));
      rd(prn_port_pkg::DATA_ADDR, 8'(dq) | de);
      rd(prn_port_pkg::STATUS_ADDR, {st, 3'h0});
      rd(prn_port_pkg::CTRL_ADDR, 8'(en * 16 + (cq | ce)));
      rd(10'h3BF, 8'hFF);
      ex = 8'(en * 16 + (cq | ce));
      wr_rd(prn_port_pkg::DATA_ADDR, r[7:0], 8'(dq) | de);
      wr_rd(prn_port_pkg::CTRL_ADDR, r[15:8], ex);
    end
    // Second reset after the random loop, printer lines quiet
    @(posedge clk);
    st <= 5'h00;
    de <= 8'h00;
    ce <= 4'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(dpo, 8'h00);
    chk({4'h0, cpo}, 8'h0B);
    chk({7'h00, irq}, 8'h00);
    rd(prn_port_pkg::CTRL_ADDR, 8'h0B);
    rd(prn_port_pkg::DATA_ADDR, 8'h00);
    end_sim();
  end
endmodule
